// file: mprs_pkg.sv
// Package with constants and carrier types for the card power and reset sequencer
// What this block does
// - Card stays off while power-enable is low
// - Power-up begins when power-enable rises
// - Restart line internally released about 50 ms
// - Low satellite disable input enables receiver
// - Low backoff input applies power reduction
// - Host wake is open-drain, pulled low
// - Link wake request drives line low
// - Clock request drives output low
// - Link held in reset while reset low
// - Restart input active low, pulled up
package mprs_pkg;

  // Clock rate in Hz
  localparam int unsigned CLK_HZ          = 50000000;
  // Millisecond tick period in cycles
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  // Typical release delay of the restart pull-up after supply, in ms
  localparam int unsigned RESTART_REL_MS  = 50;
  // Least restart pulse that is honoured, in ms
  localparam int unsigned RESTART_MIN_MS  = 200;
  // Longest restart pulse before repeated restarts, in ms
  localparam int unsigned RESTART_MAX_MS  = 700;
  // Width of the millisecond counters
  localparam int unsigned MS_W            = 10;
  // Width of the tick prescaler
  localparam int unsigned PRE_W           = 16;
  localparam logic [PRE_W-1:0] PRE_LAST   = PRE_W'(MS_CYCLES - 1);
  localparam logic [MS_W-1:0]  REL_LAST   = MS_W'(RESTART_REL_MS);
  localparam logic [MS_W-1:0]  RST_MIN    = MS_W'(RESTART_MIN_MS);
  localparam logic [MS_W-1:0]  RST_MAX    = MS_W'(RESTART_MAX_MS);
  localparam logic [MS_W-1:0]  MS_ZERO    = '0;
  localparam logic [MS_W-1:0]  MS_ONE     = MS_W'(1);

  // Card life states
  typedef enum logic [2:0] {
    MPRS_OFF,
    MPRS_BOOT,
    MPRS_RUN,
    MPRS_RESTART,
    MPRS_REBOOT
  } mprs_state_t;

  // Host-driven control pins after synchronising
  typedef struct packed {
    logic power_enable;
    logic restart_n;
    logic link_reset_n;
    logic power_backoff_n;
    logic antenna_select;
    logic gnss_disable_n;
  } mprs_ctl_t;

  // Requests raised by the card firmware side
  typedef struct packed {
    logic host_wake;
    logic link_wake;
    logic refclk_req;
  } mprs_req_t;

endpackage

// file: mprs_sync.sv
// Two-flop synchroniser for the host control pins
module mprs_sync
  import mprs_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire mprs_ctl_t d,
  output mprs_ctl_t      q
);

  // First and second stages; only stage two feeds logic
  mprs_ctl_t s1_reg;
  mprs_ctl_t s1_next;
  mprs_ctl_t s2_reg;
  mprs_ctl_t s2_next;

  // Next-state: shift the pins in
  always_comb begin
    s1_next = d;
    s2_next = s1_reg;
  end

  // Reset to the pull-resistor levels: enable low, restart high
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '{power_enable: 1'b0, restart_n: 1'b1, link_reset_n: 1'b0,
                  power_backoff_n: 1'b1, antenna_select: 1'b1, gnss_disable_n: 1'b1};
      s2_reg <= '{power_enable: 1'b0, restart_n: 1'b1, link_reset_n: 1'b0,
                  power_backoff_n: 1'b1, antenna_select: 1'b1, gnss_disable_n: 1'b1};
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  assign q = s2_reg;

endmodule

// file: mprs_card.sv
// Card-side power, restart and wake sequencer
module mprs_card
  import mprs_pkg::*;
#(
  // Last prescaler count of one millisecond; a bench may shorten it to fit its run
  parameter logic [PRE_W-1:0] TICK_LAST = PRE_LAST
)
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire mprs_ctl_t pins_in,
  input  wire mprs_req_t fw_req,
  input  wire logic      fw_power_down,
  output logic           powered,
  output logic           restart_pullup_released,
  output logic           link_in_reset,
  output logic           tx_power_reduce,
  output logic           gnss_enable,
  output logic           antenna_alt,
  output logic           host_wake_n_out,
  output logic           host_wake_n_oe,
  output logic           link_wake_n,
  output logic           refclk_request_n
);

  // Synchronised host pins
  mprs_ctl_t ctl;

  // Pins cross in from the host, so they pass two flops first
  mprs_sync u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_in),
    .q   (ctl)
  );

  // Sequencer state
  mprs_state_t state_reg;
  mprs_state_t state_next;
  // Millisecond prescaler
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  // Elapsed milliseconds in the current state
  logic [MS_W-1:0]  ms_reg;
  logic [MS_W-1:0]  ms_next;
  // Software power-down latched until enable drops or a reboot
  logic             pdn_reg;
  logic             pdn_next;
  // Registered outputs
  logic             pwr_reg, pwr_next;
  logic             rel_reg, rel_next;
  logic             lrst_reg, lrst_next;
  logic             dpr_reg, dpr_next;
  logic             gnss_reg, gnss_next;
  logic             ant_reg, ant_next;
  logic             hw_oe_reg, hw_oe_next;
  logic             lw_reg, lw_next;
  logic             ck_reg, ck_next;

  // One-cycle tick each millisecond
  logic             tick;
  // Prescaler wraps at the tick, so it never runs past the last count
  assign tick = (pre_reg == TICK_LAST);

  // Sequencer next-state
  always_comb begin
    state_next = state_reg;
    pre_next   = tick ? '0 : pre_reg + PRE_W'(1);
    ms_next    = ms_reg;
    pdn_next   = pdn_reg;
    if (tick && ms_reg != RST_MAX) begin
      // Saturate so a held restart is still measurable
      ms_next = ms_reg + MS_ONE;
    end
    unique case (state_reg)
      MPRS_OFF: begin
        pdn_next = 1'b0;
        if (ctl.power_enable) begin
          state_next = MPRS_BOOT;
          ms_next    = MS_ZERO;
        end
      end
      MPRS_BOOT: begin
        // Losing enable wins over any timing
        if (!ctl.power_enable) begin
          state_next = MPRS_OFF;
        end else if (ms_reg >= REL_LAST) begin
          state_next = MPRS_RUN;
          ms_next    = MS_ZERO;
        end
      end
      // Running: watch for power-down and restart
      MPRS_RUN: begin
        if (fw_power_down) begin
          // Card shuts down; host is expected to drop enable
          pdn_next = 1'b1;
        end
        if (!ctl.power_enable) begin
          state_next = MPRS_OFF;
        end else if (!ctl.restart_n) begin
          state_next = MPRS_RESTART;
          ms_next    = MS_ZERO;
        end
      end
      MPRS_RESTART: begin
        // Enable loss ends the pulse at once
        if (!ctl.power_enable) begin
          state_next = MPRS_OFF;
        end else if (ctl.restart_n) begin
          // Short glitches are ignored; valid pulses reboot
          state_next = (ms_reg >= RST_MIN) ? MPRS_REBOOT : MPRS_RUN;
          ms_next    = MS_ZERO;
        end else if (ms_reg == RST_MAX) begin
          // Overlong hold restarts again and again
          state_next = MPRS_REBOOT;
          ms_next    = MS_ZERO;
        end
      end
      // One cycle of reboot, then a fresh boot
      MPRS_REBOOT: begin
        // A reboot clears any pending power-down
        pdn_next = 1'b0;
        if (!ctl.power_enable) begin
          state_next = MPRS_OFF;
        end else begin
          state_next = MPRS_BOOT;
          ms_next    = MS_ZERO;
        end
      end
    endcase
  end

  // Output next values; all but the restart release idle while unpowered
  always_comb begin
    pwr_next   = (state_next != MPRS_OFF) && !pdn_next;
    // release shown once boot is over
    rel_next   = (state_next == MPRS_RUN) || (state_next == MPRS_RESTART);
    lrst_next  = !pwr_next || !ctl.link_reset_n;
    dpr_next   = pwr_next && !ctl.power_backoff_n;
    gnss_next  = pwr_next && !ctl.gnss_disable_n;
    // Antenna option passes through while powered
    ant_next   = pwr_next && ctl.antenna_select;
    hw_oe_next = pwr_next && fw_req.host_wake;
    lw_next    = !(pwr_next && fw_req.link_wake);
    ck_next    = !(pwr_next && fw_req.refclk_req);
  end

  // State and output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      // Card off, link held in reset, wake lines released
      state_reg <= MPRS_OFF;
      pre_reg   <= '0;
      ms_reg    <= MS_ZERO;
      pdn_reg   <= 1'b0;
      pwr_reg   <= 1'b0;
      rel_reg   <= 1'b0;
      lrst_reg  <= 1'b1;
      dpr_reg   <= 1'b0;
      gnss_reg  <= 1'b0;
      ant_reg   <= 1'b0;
      hw_oe_reg <= 1'b0;
      lw_reg    <= 1'b1;
      ck_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      ms_reg    <= ms_next;
      pdn_reg   <= pdn_next;
      pwr_reg   <= pwr_next;
      rel_reg   <= rel_next;
      lrst_reg  <= lrst_next;
      dpr_reg   <= dpr_next;
      gnss_reg  <= gnss_next;
      ant_reg   <= ant_next;
      hw_oe_reg <= hw_oe_next;
      lw_reg    <= lw_next;
      ck_reg    <= ck_next;
    end
  end

  assign powered                 = pwr_reg;
  assign restart_pullup_released = rel_reg;
  assign link_in_reset           = lrst_reg;
  assign tx_power_reduce         = dpr_reg;
  assign gnss_enable             = gnss_reg;
  assign antenna_alt             = ant_reg;
  // Open-drain: output level is always low, only enable moves
  assign host_wake_n_out         = 1'b0;
  assign host_wake_n_oe          = hw_oe_reg;
  assign link_wake_n             = lw_reg;
  assign refclk_request_n        = ck_reg;

  property p_off_quiet;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_OFF && !ctl.power_enable)
        |=> (!host_wake_n_oe && link_wake_n && refclk_request_n);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("card active while off");

  property p_power_up;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_OFF && ctl.power_enable) |=> (state_reg == MPRS_BOOT) ##1 powered;
  endproperty
  a_power_up: assert property (p_power_up) else $error("no power-up on enable");

  // no release before the boot span
  property p_release;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_BOOT && ms_reg < REL_LAST) |=> !restart_pullup_released;
  endproperty
  a_release: assert property (p_release) else $error("restart released too early");

  property p_link_rst;
    @(posedge clk) disable iff (rst)
      !ctl.link_reset_n |=> link_in_reset;
  endproperty
  a_link_rst: assert property (p_link_rst) else $error("link left out of reset");

  property p_dpr;
    @(posedge clk) disable iff (rst)
      (pwr_next && !ctl.power_backoff_n) |=> tx_power_reduce;
  endproperty
  a_dpr: assert property (p_dpr) else $error("backoff not applied");

  property p_gnss;
    @(posedge clk) disable iff (rst)
      (pwr_next && ctl.gnss_disable_n) |=> !gnss_enable;
  endproperty
  a_gnss: assert property (p_gnss) else $error("receiver enabled on high input");

  property p_wake;
    @(posedge clk) disable iff (rst)
      (pwr_next && fw_req.host_wake) |=> (host_wake_n_oe && !host_wake_n_out);
  endproperty
  a_wake: assert property (p_wake) else $error("host wake not pulled low");

  property p_lwake;
    @(posedge clk) disable iff (rst)
      (pwr_next && fw_req.link_wake) |=> !link_wake_n;
  endproperty
  a_lwake: assert property (p_lwake) else $error("link wake not driven low");

  property p_clkreq;
    @(posedge clk) disable iff (rst)
      (pwr_next && fw_req.refclk_req) |=> !refclk_request_n;
  endproperty
  a_clkreq: assert property (p_clkreq) else $error("clock request not low");

  // short pulse goes back to run
  property p_short_restart;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_RESTART && ctl.restart_n && ms_reg < RST_MIN && ctl.power_enable)
        |=> (state_reg == MPRS_RUN);
  endproperty
  a_short_restart: assert property (p_short_restart) else $error("short pulse restarted");

  property p_restart_enter;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_RUN && ctl.power_enable && !ctl.restart_n)
        |=> (state_reg == MPRS_RESTART);
  endproperty
  a_restart_enter: assert property (p_restart_enter) else $error("restart input ignored");

  property p_reboot;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_RESTART && ctl.power_enable && ctl.restart_n && ms_reg >= RST_MIN)
        |=> (state_reg == MPRS_REBOOT && !restart_pullup_released);
  endproperty
  a_reboot: assert property (p_reboot) else $error("valid pulse did not reboot");

  property p_overlong;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_RESTART && ctl.power_enable && !ctl.restart_n && ms_reg == RST_MAX)
        |=> (state_reg == MPRS_REBOOT);
  endproperty
  a_overlong: assert property (p_overlong) else $error("overlong hold did not reboot");

  property p_pdn;
    @(posedge clk) disable iff (rst)
      (state_reg == MPRS_RUN && fw_power_down) |=> !powered;
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down command ignored");

endmodule

// file: mprs_host.sv
// Host-side model that drives the card control pins in the documented order
module mprs_host
  import mprs_pkg::*;
#(
  parameter int unsigned GAP = 4  // Cycles standing in for one spacing step
)
(
  input  wire logic clk,
  output mprs_ctl_t  pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Enable low, restart released, link reset held, options idle high
  initial pins = 6'h17;

  // spacing counted in clock steps
  // One spacing step; a short step keeps the run within budget
  task automatic step();
    repeat (GAP) @(posedge clk);
    #1;
  endtask

  // Option levels and link reset as {link_reset_n, backoff_n, antenna, gnss_n}
  task automatic set_opts(input logic [3:0] o);
    {pins.link_reset_n, pins.power_backoff_n, pins.antenna_select, pins.gnss_disable_n} = o;
  endtask

  // Power-up with options set alongside enable
  task automatic power_up(input logic [3:0] o);
    set_opts({1'b0, o[2:0]});
    pins.power_enable = 1'b1;
    step();
    pins.link_reset_n = 1'b1;
  endtask

  // Orderly power-off
  task automatic power_down();
    pins.link_reset_n = 1'b0;
    step();
    pins.restart_n = 1'b0;
    step();
    pins.power_enable = 1'b0;
    // wait before the supply may go
    step();
    // Restart released after enable, as the card is already off
    pins.restart_n = 1'b1;
  endtask

  // Hold restart low for a number of cycles, then release it
  task automatic restart_pulse(input int unsigned n);
    // restart held for the given span
    pins.restart_n = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    pins.restart_n = 1'b1;
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the card power and reset sequencer
module tb;
  import mprs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // One table row: option pins, firmware requests, expected outputs
  typedef struct packed {
    logic [3:0] o;
    logic [2:0] r;
    logic [6:0] e;
  } mprs_row_t;

  logic       clk;            // System clock
  logic       rst;            // Synchronous reset
  mprs_ctl_t  pins;           // Host pins from the model
  mprs_req_t  fw_req;         // Firmware requests
  logic       fw_power_down;  // Software power-down command
  logic       powered;
  logic       released;
  logic       lir;
  logic       tx;
  logic       gnss;
  logic       alt;
  logic       wake_out;
  logic       wake_oe;
  logic       lw_n;
  logic       rc_n;
  int         mismatches;     // Counted failures
  int         checks;         // Counted comparisons
  int         cycles;         // Timeout counter
  logic [6:0] outs;           // Output bundle compared as one value

  // Rows: {tx, alt, gnss, link_in_reset, oe, link_wake_n, refclk_request_n}
  mprs_row_t rows [4] = '{
    '{4'h2, 3'h0, 7'h7B},
    '{4'hD, 3'h7, 7'h04},
    '{4'h9, 3'h5, 7'h46},
    '{4'h6, 3'h2, 7'h39}
  };

  assign outs = {tx, alt, gnss, lir, wake_oe, lw_n, rc_n};

  mprs_host i_mprs_host (
    .clk  (clk),
    .pins (pins)
  );

  // Four cycles stand for one millisecond, so boot and restart spans fit the run
  mprs_card #(
    .TICK_LAST (16'h0003)
  ) i_mprs_card (
    .clk                     (clk),
    .rst                     (rst),
    .pins_in                 (pins),
    .fw_req                  (fw_req),
    .fw_power_down           (fw_power_down),
    .powered                 (powered),
    .restart_pullup_released (released),
    .link_in_reset           (lir),
    .tx_power_reduce         (tx),
    .gnss_enable             (gnss),
    .antenna_alt             (alt),
    .host_wake_n_out         (wake_out),
    .host_wake_n_oe          (wake_oe),
    .link_wake_n             (lw_n),
    .refclk_request_n        (rc_n)
  );

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cut a hang short; the whole run needs well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Compare and count
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Let pins cross the synchroniser and the state update
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the power flag
  task automatic wait_pow(input logic v);
    int n;
    n = 0;
    while (powered !== v && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Bounded wait for the restart release flag
  task automatic wait_rel(input logic v);
    int n;
    n = 0;
    while (released !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    fw_req = 3'h0;
    fw_power_down = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check(outs, 7'h0B);
    check({5'h0, powered, released}, 7'h00);
    $display("reset values done");

    // Requests and options while off must not show
    i_mprs_host.set_opts(4'h9);
    fw_req = 3'h7;
    settle();
    check(outs, 7'h0B);
    check({6'h0, powered}, 7'h00);
    $display("off state done");

    // Power-up
    fw_req = 3'h0;
    i_mprs_host.power_up(4'h2);
    wait_pow(1'b1);
    check({6'h0, powered}, 7'h01);
    $display("power-up done");

    // Level table while booting
    foreach (rows[i]) begin
      i_mprs_host.set_opts(rows[i].o);
      fw_req = rows[i].r;
      settle();
      check(outs, rows[i].e);
      check({6'h0, wake_oe ? wake_out : 1'b1}, {6'h0, ~rows[i].r[2]});
      check({6'h0, released}, 7'h00);
    end
    $display("level table done");

    // Orderly power-off
    i_mprs_host.power_down();
    fw_req = 3'h7;
    settle();
    check(outs, 7'h0B);
    check({6'h0, powered}, 7'h00);
    $display("power-off done");

    // Reset in mid-run while powered
    fw_req = 3'h0;
    i_mprs_host.power_up(4'h6);
    wait_pow(1'b1);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(outs, 7'h0B);
    check({6'h0, powered}, 7'h00);
    rst = 1'b0;
    wait_pow(1'b1);
    check({6'h0, powered}, 7'h01);
    $display("mid-run reset done");

    // Boot span before the restart line is released
    repeat (150) @(posedge clk);
    #1;
    check({6'h0, released}, 7'h00);
    wait_rel(1'b1);
    check({6'h0, released}, 7'h01);
    $display("boot span done");

    // Short restart pulse is ignored, a valid one reboots
    i_mprs_host.restart_pulse(20);
    settle();
    check({5'h0, powered, released}, 7'h03);
    i_mprs_host.restart_pulse(1000);
    settle();
    check({5'h0, powered, released}, 7'h02);
    wait_rel(1'b1);
    check({6'h0, released}, 7'h01);
    $display("restart pulses done");

    // Overlong hold reboots while the line is still low
    i_mprs_host.restart_pulse(2920);
    check({5'h0, powered, released}, 7'h02);
    wait_rel(1'b1);
    check({6'h0, released}, 7'h01);
    $display("overlong restart done");

    // Software power-down holds the card off until enable drops
    fw_power_down = 1'b1;
    @(posedge clk);
    #1;
    fw_power_down = 1'b0;
    check({6'h0, powered}, 7'h00);
    settle();
    check(outs, 7'h0B);
    i_mprs_host.power_down();
    i_mprs_host.power_up(4'h2);
    wait_pow(1'b1);
    check({6'h0, powered}, 7'h01);
    $display("software power-down done");
    wrap_up();
  end
endmodule
